/* hw/aob_consts.vh */
/*
  Constants for the accelerometer output buffer readout block: register
  offsets, field positions, reset values and buffer sizes.
  Assumes inclusion by bare name from design files of the same folder.
*/
`ifndef AOB_CONSTS_VH
`define AOB_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define AOB_ADDR_W            8
`define AOB_OFF_STATE         8'h0b
`define AOB_OFF_X_LOW         8'h0c
`define AOB_OFF_X_HIGH        8'h0d
`define AOB_OFF_Y_LOW         8'h0e
`define AOB_OFF_Y_HIGH        8'h0f
`define AOB_OFF_Z_LOW         8'h10
`define AOB_OFF_Z_HIGH        8'h11
`define AOB_OFF_SETUP_ONE     8'h20
`define AOB_OFF_SETUP_TWO     8'h21
`define AOB_OFF_SENSOR_TWO    8'h22
`define AOB_OFF_SENSOR_FIVE   8'h23

// ****************************************************************
// Field positions
// ****************************************************************
`define AOB_STATE_WMRK_BIT    7
`define AOB_STATE_OVF_BIT     6
`define AOB_S1_MODE_LO        0
`define AOB_S1_MODE_HI        1
`define AOB_S1_TYPE_BIT       2
`define AOB_S2_FLUSH_BIT      7
`define AOB_SN2_ORDER_BIT     0
`define AOB_SN2_FREAD_BIT     1
`define AOB_SN5_X_BIT         0
`define AOB_SN5_Y_BIT         1
`define AOB_SN5_Z_BIT         2
`define AOB_MODE_OFF          2'h0

// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define AOB_SETUP_ONE_RST     8'h00
`define AOB_SETUP_TWO_RST     8'h00
`define AOB_SENSOR_TWO_RST    8'h00
`define AOB_SENSOR_FIVE_RST   8'h00
`define AOB_DEPTH             32
`define AOB_PTR_W             5
`define AOB_CNT_W             6
`define AOB_CNT_FULL          6'h20
`define AOB_SAMPLE_W          36
`define AOB_IN_FIFO_DEPTH     16
`define AOB_IN_FIFO_AW        4

`endif

/* hw/aob_fifo.v */
/*
  Generic valid/ready FIFO with parameterised width and depth.
  Assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module aob_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clock,     // System clock
  input  wire             reset,     // Async reset, active high
  input  wire [WIDTH-1:0] in_data,   // Write data
  input  wire             in_valid,  // Write request
  output wire             in_ready,  // Space available
  output wire [WIDTH-1:0] out_data,  // Oldest word
  output wire             out_valid, // Word available
  input  wire             out_ready  // Drain accepts word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            full  = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  wire            empty = (wr_q == rd_q);
  wire            push  = in_valid && !full;
  wire            pop   = out_valid && out_ready;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_q[AW-1:0]];

  always @(posedge clock) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

/* hw/aob_readout.v */
/*
  Readout side of a 32-entry XYZ sample buffer: stored count, overflow and
  watermark flags, FIFO/LIFO selection, byte order formatting and the
  auto-increment address walk with fast-read and per-axis skips.
  Assumes samples arrive on the same clock through a valid/ready port and
  that the host register port is single-cycle, read data one cycle later.
*/
// Operation
// - Overflow stays 0 until an arrival finds 32 stored
// - One complete sample read clears overflow
// - Flush write empties buffer, clears overflow
// - Mode 00b clears overflow, count; keeps data
// - State bits 5:0 report stored count
// - Arrival when full holds 32, sets overflow
// - FIFO shows oldest, LIFO shows newest
// - Axis values are two's complement
// - Byte order selectable, little-endian after reset
// - Little-endian: low byte, then right-justified nibble
// - Little-endian upper bits 7:4 copy sign
// - Big-endian: bits 11:4, then nibble, zeros
// - Fast read skips upper registers
// - Fast read returns top eight bits
// - Axis skip bypasses both axis registers
// - Watermark flag when count reaches level
`timescale 1ns/1ps
`include "aob_consts.vh"
module aob_readout (
  input  wire                    clock,        // 40 MHz system clock
  input  wire                    reset,        // Async reset, active high
  input  wire [`AOB_SAMPLE_W-1:0] sample_data, // {z,y,x} 12-bit two's complement
  input  wire                    sample_valid, // New triplet offered
  output wire                    sample_ready, // Input FIFO has room
  input  wire [`AOB_ADDR_W-1:0]  reg_addr,     // Register address
  input  wire [7:0]              reg_wdata,    // Write data
  input  wire                    reg_write,    // Write strobe
  input  wire                    reg_read,     // Read strobe
  output reg  [7:0]              reg_rdata_q,  // Read data, cycle after strobe
  output reg  [`AOB_ADDR_W-1:0]  next_addr_q,  // Auto-increment next address
  output reg                     overflow_flag_q, // Overflow state
  output reg                     watermark_flag_q // Watermark state
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  reg  [7:0] setup_one_q;
  reg  [7:0] setup_two_q;
  reg  [7:0] sensor_two_q;
  reg  [7:0] sensor_five_q;
  wire [1:0] buf_mode    = setup_one_q[`AOB_S1_MODE_HI:`AOB_S1_MODE_LO];
  wire       lifo_sel    = setup_one_q[`AOB_S1_TYPE_BIT];
  wire [5:0] wmrk_level  = setup_two_q[5:0];
  wire       byte_order_select = sensor_two_q[`AOB_SN2_ORDER_BIT];
  wire       fast_read   = sensor_two_q[`AOB_SN2_FREAD_BIT];
  wire       axis_x_skip = sensor_five_q[`AOB_SN5_X_BIT];
  wire       axis_y_skip = sensor_five_q[`AOB_SN5_Y_BIT];
  wire       axis_z_skip = sensor_five_q[`AOB_SN5_Z_BIT];

  wire flush_wr   = reg_write && (reg_addr == `AOB_OFF_SETUP_TWO) &&
                    reg_wdata[`AOB_S2_FLUSH_BIT];
  wire disable_wr = reg_write && (reg_addr == `AOB_OFF_SETUP_ONE) &&
                    (reg_wdata[`AOB_S1_MODE_HI:`AOB_S1_MODE_LO] == `AOB_MODE_OFF);

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      setup_one_q   <= `AOB_SETUP_ONE_RST;
      setup_two_q   <= `AOB_SETUP_TWO_RST;
      sensor_two_q  <= `AOB_SENSOR_TWO_RST;
      sensor_five_q <= `AOB_SENSOR_FIVE_RST;
    end else if (reg_write) begin
      case (reg_addr)
        `AOB_OFF_SETUP_ONE:   setup_one_q   <= reg_wdata;
        `AOB_OFF_SETUP_TWO:   setup_two_q   <= {1'b0, reg_wdata[6:0]}; // Flush self-clears
        `AOB_OFF_SENSOR_TWO:  sensor_two_q  <= reg_wdata;
        `AOB_OFF_SENSOR_FIVE: sensor_five_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Input FIFO between sample producer and buffer
  // ****************************************************************
  wire [`AOB_SAMPLE_W-1:0] in_word;
  wire                     in_avail;
  wire                     in_take;

  aob_fifo #(
    .WIDTH (`AOB_SAMPLE_W),
    .DEPTH (`AOB_IN_FIFO_DEPTH),
    .AW    (`AOB_IN_FIFO_AW)
  ) u_in_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (in_word),
    .out_valid (in_avail),
    .out_ready (in_take)
  );

  // ****************************************************************
  // Sample store
  // ****************************************************************
  reg  [`AOB_SAMPLE_W-1:0] store [0:`AOB_DEPTH-1];
  reg  [`AOB_PTR_W-1:0]    head_q;   // Next write slot
  reg  [`AOB_CNT_W-1:0]    count_q;
  wire                     full     = (count_q == `AOB_CNT_FULL);
  wire [`AOB_PTR_W-1:0]    tail_ptr = head_q - count_q[`AOB_PTR_W-1:0];
  wire [`AOB_PTR_W-1:0]    newest   = head_q - 5'h01;
  wire                     pop;

  // Drained only while the buffer is enabled; overflow arrivals displace oldest.
  // A LIFO pop steps the head back, so an arrival waits one cycle behind it.
  assign in_take = in_avail && (buf_mode != `AOB_MODE_OFF) && !flush_wr && !disable_wr &&
                   !(pop && lifo_sel);

  always @(posedge clock) begin
    if (in_take) begin
      store[head_q] <= in_word;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      head_q           <= 5'h00;
      count_q          <= 6'h00;
      overflow_flag_q  <= 1'b0;
      watermark_flag_q <= 1'b0;
    end else begin
      if (flush_wr) begin
        count_q         <= 6'h00;
        overflow_flag_q <= 1'b0;
      end else if (disable_wr) begin
        count_q         <= 6'h00;
        overflow_flag_q <= 1'b0;
      end else begin
        if (in_take) begin
          head_q <= head_q + 5'h01;
        end else if (pop && lifo_sel) begin
          head_q <= head_q - 5'h01;
        end
        if (in_take && full && !pop) begin
          overflow_flag_q <= 1'b1;
        end else if (pop) begin
          overflow_flag_q <= 1'b0;
        end
        // Count saturates at 32: a full arrival overwrites the oldest slot
        if (in_take && !pop && !full) begin
          count_q <= count_q + 6'h01;
        end else if (pop && !in_take) begin
          count_q <= count_q - 6'h01;
        end
      end
      watermark_flag_q <= (count_q >= wmrk_level) && (wmrk_level != 6'h00);
    end
  end

  // ****************************************************************
  // Presented sample and byte formatting
  // ****************************************************************
  wire [`AOB_SAMPLE_W-1:0] shown = store[lifo_sel ? newest : tail_ptr];
  wire [7:0] low_byte  [0:2];
  wire [7:0] high_byte [0:2];

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
      wire [11:0] v = shown[ax*12 +: 12];
      assign low_byte[ax]  = (fast_read || byte_order_select) ? v[11:4]
                                                              : v[7:0];
      assign high_byte[ax] = byte_order_select ? {v[3:0], 4'h0}
                                               : {{4{v[11]}}, v[11:8]};
    end
  endgenerate

  // ****************************************************************
  // Auto-increment walk over enabled data bytes
  // ****************************************************************
  wire [2:0] skip = {axis_z_skip, axis_y_skip, axis_x_skip};
  reg  [7:0] walk_next;
  reg        last_byte;
  reg  [2:0] lane;
  reg        in_data;
  reg        found;
  integer    i;

  always @* begin
    walk_next = reg_addr + 8'h01;
    last_byte = 1'b0;
    in_data   = (reg_addr >= `AOB_OFF_X_LOW) && (reg_addr <= `AOB_OFF_Z_HIGH);
    lane      = 3'h0;
    found     = 1'b0;
    if (in_data) begin
      lane = reg_addr[3:1] - 3'h6;
      // Next enabled data register after this one, else wrap to state
      for (i = 0; i < 3; i = i + 1) begin
        if (!found && (i > lane) && !skip[i]) begin
          walk_next = `AOB_OFF_X_LOW + i[7:0] * 8'h02;
          found     = 1'b1;
        end
      end
      if (!fast_read && !reg_addr[0]) begin
        walk_next = reg_addr + 8'h01;
        found     = 1'b1;
      end
      if (!found) begin
        walk_next = `AOB_OFF_STATE;
        last_byte = 1'b1;
      end
      // Fast read: upper register never visited, low register ends the axis
      if (fast_read && reg_addr[0]) begin
        last_byte = 1'b0;
      end
    end
    // From the state register the walk starts at the first enabled axis
    if (reg_addr == `AOB_OFF_STATE) begin
      for (i = 0; i < 3; i = i + 1) begin
        if (!found && !skip[i]) begin
          walk_next = `AOB_OFF_X_LOW + i[7:0] * 8'h02;
          found     = 1'b1;
        end
      end
    end
  end

  // Pop only on the final byte the walk would visit for this sample
  assign pop = reg_read && in_data && last_byte && (count_q != 6'h00) &&
               !flush_wr && !disable_wr;

  // ****************************************************************
  // Read port
  // ****************************************************************
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
      next_addr_q <= `AOB_OFF_STATE;
    end else if (reg_read) begin
      next_addr_q <= walk_next;
      case (reg_addr)
        `AOB_OFF_STATE:       reg_rdata_q <= {watermark_flag_q, overflow_flag_q,
                                              count_q};
        `AOB_OFF_X_LOW:       reg_rdata_q <= low_byte[0];
        `AOB_OFF_X_HIGH:      reg_rdata_q <= high_byte[0];
        `AOB_OFF_Y_LOW:       reg_rdata_q <= low_byte[1];
        `AOB_OFF_Y_HIGH:      reg_rdata_q <= high_byte[1];
        `AOB_OFF_Z_LOW:       reg_rdata_q <= low_byte[2];
        `AOB_OFF_Z_HIGH:      reg_rdata_q <= high_byte[2];
        `AOB_OFF_SETUP_ONE:   reg_rdata_q <= setup_one_q;
        `AOB_OFF_SETUP_TWO:   reg_rdata_q <= setup_two_q;
        `AOB_OFF_SENSOR_TWO:  reg_rdata_q <= sensor_two_q;
        `AOB_OFF_SENSOR_FIVE: reg_rdata_q <= sensor_five_q;
        default:              reg_rdata_q <= 8'h00;
      endcase
    end
  end
endmodule

/* tb/aob_host.sv */
/*
  Host model: drives the register port of the readout block.
  Assumes one clock; strobes change just after a rising edge.
*/
`timescale 1ns/1ps
module aob_host (
  input  wire       clock, // Clock
  input  wire [7:0] rdata, // Read data
  output reg  [7:0] addr,  // Address
  output reg  [7:0] wdata, // Write data
  output reg        write, // Write strobe
  output reg        read   // Read strobe
);
  initial {addr, wdata, write, read} = 18'h0;

  task wr(input [7:0] a, input [7:0] x);
    @(posedge clock);
    addr <= a;
    wdata <= x;
    write <= 1'b1;
    @(posedge clock);
    write <= 1'b0;
  endtask

  // Data appear on the edge after the strobe and hold until the next read; take them one edge later
  task rd(input [7:0] a, output [7:0] x);
    @(posedge clock);
    addr <= a;
    read <= 1'b1;
    @(posedge clock);
    read <= 1'b0;
    @(posedge clock);
    x = rdata;
  endtask

  function [11:0] be_join(input [7:0] lo, input [7:0] hi);
    be_join = {lo, hi[7:4]};
  endfunction
endmodule

/* tb/aob_readout_properties.sv */
/*
  Checker for the readout block, bound to its ports.
  Assumes reset is asynchronous and active high.
*/
`timescale 1ns/1ps
module aob_readout_properties (
  input wire       clock,          // Clock
  input wire       reset,          // Reset
  input wire [7:0] reg_addr,       // Address
  input wire [7:0] reg_wdata,      // Write data
  input wire       reg_write,      // Write strobe
  input wire       reg_read,       // Read strobe
  input wire [7:0] reg_rdata_q,    // Read data
  input wire [7:0] next_addr_q,    // Next address
  input wire       overflow_flag_q // Overflow
);
  // Shadows of the format and skip setups, kept from the writes
  reg  [7:0] fmt_q;
  reg  [7:0] skip_q;
  wire       acc = reg_read || reg_write;
  wire       flush_w = reg_write && reg_addr == 8'h21 && reg_wdata[7];
  wire       off_w = reg_write && reg_addr == 8'h20 && reg_wdata[1:0] == 2'h0;
  wire       hi_rd = reg_read && reg_addr[0] && reg_addr > 8'h0c && reg_addr < 8'h12;
  wire       rd_c = reg_read && reg_addr == 8'h0c;

  always @(posedge clock or posedge reset)
    if (reset)
      {fmt_q, skip_q} <= 16'h0;
    else if (reg_write && reg_addr == 8'h22)
      fmt_q <= reg_wdata;
    else if (reg_write && reg_addr == 8'h23)
      skip_q <= reg_wdata;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  flush_clr_a: assert property (flush_w |=> !overflow_flag_q)
    else $error("overflow set after flush");
  off_clr_a: assert property (off_w |=> !overflow_flag_q)
    else $error("overflow set after disable");
  ovf_fall_a: assert property ($fell(overflow_flag_q) |-> $past(acc) || $past(acc, 2))
    else $error("overflow cleared without access");
  state_rd_a: assert property (reg_read && reg_addr == 8'h0b |=>
    reg_rdata_q[6] == $past(overflow_flag_q) && reg_rdata_q[5:0] <= 6'h20)
    else $error("bad buffer state read");
  be_nib_a: assert property (hi_rd && fmt_q[1:0] == 2'h1 |=> reg_rdata_q[3:0] == 4'h0)
    else $error("big-endian nibble not zero");
  le_sign_a: assert property (hi_rd && fmt_q[1:0] == 2'h0 |=>
    reg_rdata_q[7:4] == {4{reg_rdata_q[3]}}) else $error("sign copies wrong");
  fast_step_a: assert property (rd_c && fmt_q[1] && skip_q[2:0] == 3'h0 |=>
    next_addr_q == 8'h0e) else $error("fast read visits upper byte");
  skip_step_a: assert property (reg_read && reg_addr == 8'h0d && fmt_q[1:0] == 2'h0 &&
    skip_q[2:0] == 3'h2 |=> next_addr_q == 8'h10) else $error("skipped axis visited");
  walk_start_a: assert property (reg_read && reg_addr == 8'h0b && skip_q[2:0] == 3'h1 |=>
    next_addr_q == 8'h0e) else $error("walk starts on skipped axis");
endmodule

bind aob_readout aob_readout_properties i_props (.clock(clock), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata_q(reg_rdata_q), .next_addr_q(next_addr_q), .overflow_flag_q(overflow_flag_q));

/* tb/tb.sv */
/*
  Testbench: sample pushes and host register walks with expected bytes.
  Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module tb;
  reg         clock;
  reg         reset;
  reg  [35:0] sample_data;
  reg         sample_valid;
  wire        sample_ready;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata_q, next_addr_q;
  wire        reg_write, reg_read, overflow_flag_q, watermark_flag_q;
  reg  [7:0]  d;
  reg  [7:0]  e;
  reg  [11:0] t;
  integer     failures, num_checks, k;

  always #12.5 clock = ~clock;

  aob_readout i_aob_readout (.clock(clock), .reset(reset), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_q(reg_rdata_q), .next_addr_q(next_addr_q),
    .overflow_flag_q(overflow_flag_q), .watermark_flag_q(watermark_flag_q));
  aob_host host (.clock(clock), .rdata(reg_rdata_q), .addr(reg_addr), .wdata(reg_wdata),
    .write(reg_write), .read(reg_read));

  // ********
  // Tasks
  // ********
  function [11:0] vk(input integer n);
    vk = 12'h7fe + 12'h0c0 * n[11:0];
  endfunction

  task check(input [15:0] got, input [15:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task rchk(input [7:0] a, input [7:0] x);
    host.rd(a, d);
    check({8'h00, d}, {8'h00, x});
  endtask

  // Arrivals land a few cycles late, so poll a bounded number of times
  task state_is(input [7:0] x);
    integer n;
    for (n = 0; n < 12; n = n + 1)
      if (d !== x || n == 0) host.rd(8'h0b, d);
    check({8'h00, d}, {8'h00, x});
  endtask

  task push(input [11:0] v);
    @(posedge clock);
    sample_data <= {v + 12'h002, v + 12'h001, v};
    sample_valid <= 1'b1;
    @(posedge clock);
    while (sample_ready !== 1'b1) @(posedge clock);
    sample_valid <= 1'b0;
  endtask

  task read_smp(input [11:0] v, input [2:0] m);
    integer    a;
    reg [11:0] w;
    for (a = 0; a < 3; a = a + 1) begin
      w = v + a[11:0];
      if (!m[a]) begin
        rchk(8'h0c + 8'h02 * a[7:0], w[7:0]);
        rchk(8'h0d + 8'h02 * a[7:0], {{4{w[11]}}, w[11:8]});
      end
    end
  endtask

  task tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    #200000;
    failures = failures + 1;
    tally_and_finish;
  end

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    failures = 0;
    num_checks = 0;
    sample_valid = 1'b0;
    sample_data = 36'h0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rchk(8'h0b, 8'h00);
    host.wr(8'h20, 8'h01);
    for (k = 0; k < 3; k = k + 1) push(vk(k));
    state_is(8'h03);
    read_smp(vk(0), 3'h0);
    state_is(8'h02);
    host.wr(8'h20, 8'h05);
    t = vk(2);
    rchk(8'h0c, t[7:0]);
    host.wr(8'h20, 8'h01);
    $display("test order done");
    host.wr(8'h22, 8'h01);
    host.rd(8'h0c, e);
    host.rd(8'h0d, d);
    check({4'h0, host.be_join(e, d)}, {4'h0, vk(1)});
    check({12'h000, d[3:0]}, 16'h0000);
    host.wr(8'h22, 8'h02);
    for (k = 0; k < 3; k = k + 1) begin
      t = vk(1) + k[11:0];
      rchk(8'h0c + 8'h02 * k[7:0], t[11:4]);
      if (k == 0) check({8'h00, next_addr_q}, 16'h000e);
    end
    state_is(8'h01);
    $display("test format done");
    host.wr(8'h22, 8'h00);
    host.wr(8'h23, 8'h01);
    host.rd(8'h0b, d);
    check({8'h00, next_addr_q}, 16'h000e);
    host.wr(8'h23, 8'h02);
    read_smp(vk(2), 3'h2);
    state_is(8'h00);
    host.wr(8'h23, 8'h00);
    $display("test skip done");
    for (k = 0; k < 32; k = k + 1) push(k[11:0]);
    state_is(8'h20);
    host.wr(8'h21, 8'h10);
    state_is(8'ha0);
    check({15'h0000, watermark_flag_q}, 16'h0001);
    push(12'h000);
    state_is(8'he0);
    check({15'h0000, overflow_flag_q}, 16'h0001);
    read_smp(12'h001, 3'h0);
    state_is(8'h9f);
    host.wr(8'h21, 8'h90);
    state_is(8'h00);
    check({14'h0000, watermark_flag_q, overflow_flag_q}, 16'h0000);
    rchk(8'h21, 8'h10);
    rchk(8'h12, 8'h00);
    for (k = 0; k < 33; k = k + 1) push(k[11:0]);
    state_is(8'he0);
    host.wr(8'h20, 8'h00);
    state_is(8'h00);
    $display("test overflow done");
    host.wr(8'h20, 8'h05);
    push(12'h100);
    push(12'h200);
    state_is(8'h02);
    read_smp(12'h200, 3'h0);
    read_smp(12'h100, 3'h0);
    state_is(8'h00);
    $display("test lifo done");
    tally_and_finish;
  end
endmodule
